// ### inc/rlt_pkg.sv
package rlt_pkg;

    localparam int unsigned BYTE_W = 8;

    // Special function register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL    = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW_BYTE  = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH_BYTE = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW_BYTE   = 8'h94;
    localparam logic [7:0] ADDR_COUNT_HIGH_BYTE  = 8'h95;

    // Control register bit positions
    localparam int unsigned BIT_HIGH_OVERFLOW_FLAG      = 7;
    localparam int unsigned BIT_LOW_OVERFLOW_FLAG       = 6;
    localparam int unsigned BIT_LOW_OVERFLOW_IRQ_ENABLE = 5;
    localparam int unsigned BIT_SPLIT_MODE_SELECT       = 3;
    localparam int unsigned BIT_RUN_CONTROL             = 2;
    localparam int unsigned BIT_EXTERNAL_CLOCK_SELECT   = 0;
    localparam int unsigned BIT_UNUSED_UPPER            = 4;
    localparam int unsigned BIT_UNUSED_LOWER            = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic       RST_BIT   = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Counter limits
    localparam logic [7:0]  BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;
    localparam logic [7:0]  BYTE_ONE = 8'h01;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    // Prescaler ratios
    localparam int unsigned SYS_DIV = 12;
    localparam int unsigned EXT_DIV = 8;

endpackage : rlt_pkg

// ### src/rlt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module rlt_tick_gen
    import rlt_pkg::*;
#(
    parameter int unsigned SYS_DIVIDE = SYS_DIV,
    parameter int unsigned EXT_DIVIDE = EXT_DIV
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic ext_osc_i,
    output var  logic sys_div_tick_o,
    output var  logic ext_div_tick_o
);

    localparam int unsigned SW = $clog2(SYS_DIVIDE);
    localparam int unsigned EW = $clog2(EXT_DIVIDE);
    localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIVIDE - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIVIDE - 1);

    logic [SW-1:0] sys_cnt_ff;
    logic [EW-1:0] ext_cnt_ff;
    logic          osc_meta_ff;
    logic          osc_sync_ff;
    logic          osc_prev_ff;
    logic          osc_rise;

    ////////////////////////////////////////////////////////////////////////
    // System clock prescaler
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sys_cnt_ff     <= '0;
            sys_div_tick_o <= 1'b0;
        end else if (ce_i) begin
            sys_div_tick_o <= (sys_cnt_ff == SYS_LAST);
            if (sys_cnt_ff == SYS_LAST) begin
                sys_cnt_ff <= '0;
            end else begin
                sys_cnt_ff <= sys_cnt_ff + SW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External oscillator: synchronised before it is divided
    // synchronise oscillator tick
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osc_meta_ff <= 1'b0;
            osc_sync_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
        end else if (ce_i) begin
            osc_meta_ff <= ext_osc_i;
            osc_sync_ff <= osc_meta_ff;
            osc_prev_ff <= osc_sync_ff;
        end
    end

    // An oscillator faster than ref_clk_i loses edges here
    assign osc_rise = osc_sync_ff & ~osc_prev_ff;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ext_cnt_ff     <= '0;
            ext_div_tick_o <= 1'b0;
        end else if (ce_i) begin
            ext_div_tick_o <= osc_rise && (ext_cnt_ff == EXT_LAST);
            if (osc_rise) begin
                ext_cnt_ff <= (ext_cnt_ff == EXT_LAST) ? '0 : ext_cnt_ff + EW'(1);
            end
        end
    end

endmodule : rlt_tick_gen

`default_nettype wire

// ### src/rlt_timer.sv
// How it works
// - Split bit 0 gives one 16-bit reload counter; 1 gives two 8-bit counters.
// - 16-bit rollover from FFFF loads both reload bytes and sets high flag.
// - 16-bit mode: every full overflow requests interrupt when timer interrupt enabled.
// - 16-bit mode: low byte rollover also interrupts when low enable set.
// - Split mode: each byte reloads from its own reload register on overflow.
// - Split mode: run bit gates only high byte; low byte always counts.
// - Run bit 0 stops the timer, 1 runs it; gates whole counter in 16-bit.
// - Per-byte select 1 uses system clock, 0 uses external-clock selection.
// - External select 0 picks system clock /12, 1 picks oscillator /8.
// - Oscillator /8 tick is synchronised; oscillator must not exceed system clock.
// - High byte rollover from FF to its reload value sets high overflow flag.
// - Low byte rollover from FF sets low flag in both modes.
// - Split mode: high overflow interrupts; with low enable either byte interrupts.
// - Hardware never clears overflow flags; software writes zero to clear them.
// - Control bits 4 and 1 read zero and ignore writes.
// - Count registers show 16-bit halves, or two independent 8-bit counts.
`timescale 1ns/1ps
`default_nettype none

module rlt_timer
    import rlt_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       ext_osc_i,
    input  wire logic       high_byte_clock_select_i,
    input  wire logic       low_byte_clock_select_i,
    input  wire logic       timer_irq_enable_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_rd_i,
    output var  logic [7:0] sfr_rdata_o,
    output var  logic       irq_o
);

    logic       high_overflow_flag_ff;
    logic       low_overflow_flag_ff;
    logic       low_overflow_irq_enable_ff;
    logic       split_mode_select_ff;
    logic       run_control_ff;
    logic       external_clock_select_ff;
    logic [7:0] reload_low_byte_ff;
    logic [7:0] reload_high_byte_ff;
    logic [7:0] count_low_byte_ff;
    logic [7:0] count_high_byte_ff;
    logic [7:0] nxt_count_low_byte;
    logic [7:0] nxt_count_high_byte;
    logic [7:0] control_view;
    logic       sys_div_tick;
    logic       ext_div_tick;
    logic       ext_tick;
    logic       low_tick;
    logic       high_tick;
    logic       low_rollover;
    logic       high_rollover;
    logic       wr_control;
    logic       wr_reload_low;
    logic       wr_reload_high;
    logic       wr_count_low;
    logic       wr_count_high;
    logic [15:0] count_word;

    ////////////////////////////////////////////////////////////////////////
    // Tick sources
    rlt_tick_gen #(
        .SYS_DIVIDE (SYS_DIV),
        .EXT_DIVIDE (EXT_DIV)
    ) u_tick_gen (
        .ref_clk_i      (ref_clk_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .ext_osc_i      (ext_osc_i),
        .sys_div_tick_o (sys_div_tick),
        .ext_div_tick_o (ext_div_tick)
    );

    assign ext_tick = external_clock_select_ff ? ext_div_tick : sys_div_tick;
    assign low_tick  = low_byte_clock_select_i  ? 1'b1 : ext_tick;
    assign high_tick = high_byte_clock_select_i ? 1'b1 : ext_tick;

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode
    assign wr_control     = sfr_wr_i && (sfr_addr_i == ADDR_TIMER_CONTROL);
    assign wr_reload_low  = sfr_wr_i && (sfr_addr_i == ADDR_RELOAD_LOW_BYTE);
    assign wr_reload_high = sfr_wr_i && (sfr_addr_i == ADDR_RELOAD_HIGH_BYTE);
    assign wr_count_low   = sfr_wr_i && (sfr_addr_i == ADDR_COUNT_LOW_BYTE);
    assign wr_count_high  = sfr_wr_i && (sfr_addr_i == ADDR_COUNT_HIGH_BYTE);
    assign count_word     = {count_high_byte_ff, count_low_byte_ff};

    always_comb begin
        control_view                              = READ_ZERO;
        control_view[BIT_HIGH_OVERFLOW_FLAG]      = high_overflow_flag_ff;
        control_view[BIT_LOW_OVERFLOW_FLAG]       = low_overflow_flag_ff;
        control_view[BIT_LOW_OVERFLOW_IRQ_ENABLE] = low_overflow_irq_enable_ff;
        control_view[BIT_SPLIT_MODE_SELECT]       = split_mode_select_ff;
        control_view[BIT_RUN_CONTROL]             = run_control_ff;
        control_view[BIT_EXTERNAL_CLOCK_SELECT]   = external_clock_select_ff;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= RST_BYTE;
        end else if (ce_i && sfr_rd_i) begin
            unique case (sfr_addr_i)
                ADDR_TIMER_CONTROL:    sfr_rdata_o <= control_view;
                ADDR_RELOAD_LOW_BYTE:  sfr_rdata_o <= reload_low_byte_ff;
                ADDR_RELOAD_HIGH_BYTE: sfr_rdata_o <= reload_high_byte_ff;
                ADDR_COUNT_LOW_BYTE:   sfr_rdata_o <= count_low_byte_ff;
                ADDR_COUNT_HIGH_BYTE:  sfr_rdata_o <= count_high_byte_ff;
                default:               sfr_rdata_o <= READ_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and reload registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            low_overflow_irq_enable_ff <= RST_BIT;
            split_mode_select_ff       <= RST_BIT;
            run_control_ff             <= RST_BIT;
            external_clock_select_ff   <= RST_BIT;
        end else if (ce_i && wr_control) begin
            low_overflow_irq_enable_ff <= sfr_wdata_i[BIT_LOW_OVERFLOW_IRQ_ENABLE];
            split_mode_select_ff       <= sfr_wdata_i[BIT_SPLIT_MODE_SELECT];
            run_control_ff             <= sfr_wdata_i[BIT_RUN_CONTROL];
            external_clock_select_ff   <= sfr_wdata_i[BIT_EXTERNAL_CLOCK_SELECT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reload_low_byte_ff  <= RST_BYTE;
            reload_high_byte_ff <= RST_BYTE;
        end else if (ce_i) begin
            if (wr_reload_low) begin
                reload_low_byte_ff <= sfr_wdata_i;
            end
            if (wr_reload_high) begin
                reload_high_byte_ff <= sfr_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter next state
    always_comb begin
        nxt_count_low_byte  = count_low_byte_ff;
        nxt_count_high_byte = count_high_byte_ff;
        low_rollover        = 1'b0;
        high_rollover       = 1'b0;
        if (!split_mode_select_ff) begin
            if (run_control_ff && low_tick) begin
                low_rollover = (count_low_byte_ff == BYTE_MAX);
                if (count_word == WORD_MAX) begin
                    high_rollover = 1'b1;
                    {nxt_count_high_byte, nxt_count_low_byte} = {reload_high_byte_ff, reload_low_byte_ff};
                end else begin
                    {nxt_count_high_byte, nxt_count_low_byte} = count_word + WORD_ONE;
                end
            end
        end else begin
            if (low_tick) begin
                if (count_low_byte_ff == BYTE_MAX) begin
                    low_rollover       = 1'b1;
                    nxt_count_low_byte = reload_low_byte_ff;
                end else begin
                    nxt_count_low_byte = count_low_byte_ff + BYTE_ONE;
                end
            end
            if (run_control_ff && high_tick) begin
                if (count_high_byte_ff == BYTE_MAX) begin
                    high_rollover       = 1'b1;
                    nxt_count_high_byte = reload_high_byte_ff;
                end else begin
                    nxt_count_high_byte = count_high_byte_ff + BYTE_ONE;
                end
            end
        end
        if (wr_count_low) begin
            nxt_count_low_byte = sfr_wdata_i;
        end
        if (wr_count_high) begin
            nxt_count_high_byte = sfr_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_low_byte_ff  <= RST_BYTE;
            count_high_byte_ff <= RST_BYTE;
        end else if (ce_i) begin
            count_low_byte_ff  <= nxt_count_low_byte;
            count_high_byte_ff <= nxt_count_high_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overflow flags: a rollover in the clearing cycle keeps the flag set
    // high and low flag set
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            high_overflow_flag_ff <= RST_BIT;
            low_overflow_flag_ff  <= RST_BIT;
        end else if (ce_i) begin
            if (high_rollover) begin
                high_overflow_flag_ff <= 1'b1;
            end else if (wr_control) begin
                high_overflow_flag_ff <= sfr_wdata_i[BIT_HIGH_OVERFLOW_FLAG];
            end
            if (low_rollover) begin
                low_overflow_flag_ff <= 1'b1;
            end else if (wr_control) begin
                low_overflow_flag_ff <= sfr_wdata_i[BIT_LOW_OVERFLOW_FLAG];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request; mode does not change the equation
    // full and low overflow interrupt
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= timer_irq_enable_i &&
                     (high_overflow_flag_ff || (low_overflow_irq_enable_ff && low_overflow_flag_ff));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_full_reload: assert property (
        ce_i && !split_mode_select_ff && run_control_ff && low_tick && count_word == WORD_MAX
        && !wr_count_low && !wr_count_high
        |=> count_word == {$past(reload_high_byte_ff), $past(reload_low_byte_ff)} && high_overflow_flag_ff)
        else $error("16-bit overflow did not reload or flag");

    a_split_low_reload: assert property (
        ce_i && split_mode_select_ff && low_tick && count_low_byte_ff == BYTE_MAX && !wr_count_low
        |=> count_low_byte_ff == $past(reload_low_byte_ff) && low_overflow_flag_ff)
        else $error("split low byte did not reload or flag");

    a_low_free_run: assert property (
        ce_i && split_mode_select_ff && !run_control_ff && low_byte_clock_select_i
        && count_low_byte_ff != BYTE_MAX && !wr_count_low
        |=> count_low_byte_ff == $past(count_low_byte_ff) + BYTE_ONE)
        else $error("split low byte stalled");

    a_high_stopped: assert property (
        ce_i && !run_control_ff && !wr_count_high |=> $stable(count_high_byte_ff))
        else $error("high byte moved while stopped");

    a_split_high_wrap: assert property (
        ce_i && split_mode_select_ff && run_control_ff && high_tick && count_high_byte_ff == BYTE_MAX
        && !wr_count_high
        |=> count_high_byte_ff == $past(reload_high_byte_ff) && high_overflow_flag_ff)
        else $error("split high byte did not reload or flag");

    a_flag_sticky: assert property (
        high_overflow_flag_ff && !(ce_i && wr_control) |=> high_overflow_flag_ff)
        else $error("high flag cleared without a write");

    a_irq_high: assert property (
        ce_i && timer_irq_enable_i && high_overflow_flag_ff |=> irq_o)
        else $error("no request for high overflow");

    a_irq_low: assert property (
        ce_i && timer_irq_enable_i && low_overflow_irq_enable_ff && low_overflow_flag_ff |=> irq_o)
        else $error("no request for low overflow");

    a_irq_masked: assert property (
        ce_i && !timer_irq_enable_i |=> !irq_o)
        else $error("request while timer interrupt disabled");

    a_unused_zero: assert property (
        ce_i && sfr_rd_i && sfr_addr_i == ADDR_TIMER_CONTROL
        |=> sfr_rdata_o[BIT_UNUSED_UPPER] == 1'b0 && sfr_rdata_o[BIT_UNUSED_LOWER] == 1'b0)
        else $error("unused control bits read nonzero");

    c_full_overflow: cover property (ce_i && !split_mode_select_ff && high_rollover);
    c_split_both: cover property (ce_i && split_mode_select_ff && low_rollover && high_rollover);
    c_ext_tick: cover property (ce_i && external_clock_select_ff && ext_div_tick);
    c_irq_raised: cover property (!irq_o ##1 irq_o);

endmodule : rlt_timer

`default_nettype wire

// ### testbench/rlt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rlt_timer_tb;
    import rlt_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } rlt_row_t;

    logic       ref_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce_i = 1'b1;
    logic       ext_osc_i = 1'b0;
    logic       hsel = 1'b0;
    logic       lsel = 1'b0;
    logic       irq_en = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic       irq_o;
    logic [7:0] val;
    int         num_errors = 0;
    int         comparisons = 0;
    // Ordinary register traffic: write, then read back through the same address
    rlt_row_t   rows [8] = '{'{8'h91, 8'hFF, 8'hED}, '{8'h91, 8'h00, 8'h00}, '{8'h92, 8'hA5, 8'hA5},
                             '{8'h93, 8'h5A, 8'h5A}, '{8'h94, 8'h3C, 8'h3C}, '{8'h95, 8'hC3, 8'hC3},
                             '{8'h96, 8'h77, 8'h00}, '{8'h90, 8'h12, 8'h00}};

    rlt_timer DUT (
        .ref_clk_i                (ref_clk_i),
        .rst_i                    (rst_i),
        .ce_i                     (ce_i),
        .ext_osc_i                (ext_osc_i),
        .high_byte_clock_select_i (hsel),
        .low_byte_clock_select_i  (lsel),
        .timer_irq_enable_i       (irq_en),
        .sfr_addr_i               (sfr_addr),
        .sfr_wr_i                 (sfr_wr),
        .sfr_wdata_i              (sfr_wdata),
        .sfr_rd_i                 (sfr_rd),
        .sfr_rdata_o              (sfr_rdata_o),
        .irq_o                    (irq_o)
    );

    always #2.5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        sfr_addr = addr;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        data = sfr_rdata_o;
    endtask : rd

    // Masked read compare; a partial mask is used where a byte keeps counting every cycle after its reload
    task automatic rdchk(input string what, input logic [7:0] addr, input logic [7:0] mask,
                         input logic [7:0] exp);
        logic [7:0] d;
        rd(addr, d);
        chk8(what, d & mask, exp);
    endtask : rdchk

    task automatic wait_irq(input logic exp, input int lim);
        int i;
        i = 0;
        while (irq_o !== exp && i < lim) begin
            tick(1);
            i++;
        end
        chk1("irq_o", irq_o, exp);
    endtask : wait_irq

    task automatic stop_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end

    initial begin
        tick(12);
        rst_i = 1'b0;
        for (int a = 8'h91; a <= 8'h95; a++)
            rdchk("reset value", a[7:0], 8'hFF, 8'h00);
        chk1("irq after reset", irq_o, 1'b0);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk("register readback", rows[i].addr, 8'hFF, rows[i].rexp);
        end
        // 16-bit rollover from FFFD, reload 1234
        lsel = 1'b1;
        irq_en = 1'b1;
        wr(ADDR_RELOAD_LOW_BYTE, 8'h34);
        wr(ADDR_RELOAD_HIGH_BYTE, 8'h12);
        wr(ADDR_COUNT_LOW_BYTE, 8'hFD);
        wr(ADDR_COUNT_HIGH_BYTE, 8'hFF);
        wr(ADDR_TIMER_CONTROL, 8'h04);
        wait_irq(1'b1, 10);
        wr(ADDR_TIMER_CONTROL, 8'hC0);
        rdchk("full overflow flags", ADDR_TIMER_CONTROL, 8'hFF, 8'hC0);
        rdchk("reloaded high", ADDR_COUNT_HIGH_BYTE, 8'hFF, 8'h12);
        rd(ADDR_COUNT_LOW_BYTE, val);
        tick(6);
        rdchk("stopped count", ADDR_COUNT_LOW_BYTE, 8'hFF, val);
        chk1("flags kept", irq_o, 1'b1);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wait_irq(1'b0, 2);
        // Low byte rollover in 16-bit mode
        wr(ADDR_COUNT_LOW_BYTE, 8'hFE);
        wr(ADDR_COUNT_HIGH_BYTE, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h24);
        wait_irq(1'b1, 10);
        wr(ADDR_TIMER_CONTROL, 8'h60);
        rdchk("low flag only", ADDR_TIMER_CONTROL, 8'hFF, 8'h60);
        rdchk("carry into high", ADDR_COUNT_HIGH_BYTE, 8'hFF, 8'h01);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        wait_irq(1'b0, 2);
        wr(ADDR_TIMER_CONTROL, 8'h80);
        irq_en = 1'b0;
        tick(2);
        chk1("irq masked", irq_o, 1'b0);
        irq_en = 1'b1;
        wait_irq(1'b1, 2);
        // Split mode: low byte runs with run bit clear, high byte held
        wr(ADDR_RELOAD_LOW_BYTE, 8'h80);
        wr(ADDR_RELOAD_HIGH_BYTE, 8'h40);
        wr(ADDR_COUNT_LOW_BYTE, 8'hFE);
        wr(ADDR_COUNT_HIGH_BYTE, 8'hF0);
        hsel = 1'b1;
        wr(ADDR_TIMER_CONTROL, 8'h09);
        tick(4);
        lsel = 1'b0;
        tick(1);
        rdchk("split low flag", ADDR_TIMER_CONTROL, 8'hFF, 8'h49);
        chk1("split low no irq", irq_o, 1'b0);
        rdchk("low reload", ADDR_COUNT_LOW_BYTE, 8'hF8, 8'h80);
        rdchk("high held", ADDR_COUNT_HIGH_BYTE, 8'hFF, 8'hF0);
        wr(ADDR_TIMER_CONTROL, 8'h4D);
        wait_irq(1'b1, 30);
        hsel = 1'b0;
        tick(1);
        rdchk("split both flags", ADDR_TIMER_CONTROL, 8'hFF, 8'hCD);
        rdchk("high reload", ADDR_COUNT_HIGH_BYTE, 8'hF0, 8'h40);
        wr(ADDR_TIMER_CONTROL, 8'h2D);
        wait_irq(1'b0, 2);
        wr(ADDR_TIMER_CONTROL, 8'h6D);
        wait_irq(1'b1, 2);
        // Oscillator over eight: 16 rises give two ticks
        wr(ADDR_TIMER_CONTROL, 8'h05);
        wr(ADDR_COUNT_LOW_BYTE, 8'h00);
        wr(ADDR_COUNT_HIGH_BYTE, 8'h00);
        repeat (16) begin
            ext_osc_i = 1'b1;
            tick(2);
            ext_osc_i = 1'b0;
            tick(2);
        end
        tick(8);
        wr(ADDR_TIMER_CONTROL, 8'h01);
        rdchk("ext over 8", ADDR_COUNT_LOW_BYTE, 8'hFF, 8'h02);
        // System clock over twelve over 120 cycles
        wr(ADDR_COUNT_LOW_BYTE, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h04);
        tick(119);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        // 120 run edges hold exactly ten prescaler ticks whatever its phase
        rd(ADDR_COUNT_LOW_BYTE, val);
        chk8("sys over 12", val, 8'h0A);
        // Clock enable low freezes the running count: one step only, after it returns
        wr(ADDR_COUNT_LOW_BYTE, 8'h00);
        lsel = 1'b1;
        wr(ADDR_TIMER_CONTROL, 8'h04);
        ce_i = 1'b0;
        tick(10);
        ce_i = 1'b1;
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rdchk("count under enable low", ADDR_COUNT_LOW_BYTE, 8'hFF, 8'h01);
        // Reset in mid-run with a pending request
        wr(ADDR_TIMER_CONTROL, 8'hA4);
        lsel = 1'b1;
        wait_irq(1'b1, 2);
        rst_i = 1'b1;
        tick(1);
        rst_i = 1'b0;
        chk1("irq after mid reset", irq_o, 1'b0);
        lsel = 1'b0;
        rdchk("control after mid reset", ADDR_TIMER_CONTROL, 8'hFF, 8'h00);
        rdchk("count after mid reset", ADDR_COUNT_LOW_BYTE, 8'hFF, 8'h00);
        stop_test();
    end

endmodule : rlt_timer_tb

`default_nettype wire
